// ### dv/clock_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defs.vh"
// ****************************************************************
// port checker for the clock controller
// ****************************************************************
module clock_control_monitor (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // straps and status
  input wire logic        switch_permit_config_bit,
  input wire logic [2:0]  initial_source_config,
  input wire logic        fail_safe_config_enable,
  input wire logic        watchdog_enable,
  input wire logic        new_clock_tick,
  // clock tree
  input wire logic [7:0]  osc_enable,
  input wire logic [2:0]  system_clock_select,
  input wire logic        fail_safe_active
);
  // read access phase; data was loaded at the setup edge
  wire rd_acc = psel && penable && !pwrite;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  fs_gate_a: assert property (
    fail_safe_active == (fail_safe_config_enable && !switch_permit_config_bit))
    else $error("fail safe gating wrong");
  strap_code_a: assert property (
    $past(presetn) && switch_permit_config_bit |->
    system_clock_select == $past(initial_source_config))
    else $error("current code ignores strap");
  req_held_a: assert property (
    rd_acc && paddr == `OFS_OSC_CTRL && switch_permit_config_bit |->
    prdata[0] == 1'b0) else $error("request bit set while locked");
  hop_tick_a: assert property (
    $past(presetn, 2) && $changed(system_clock_select) |->
    $past(new_clock_tick) && !switch_permit_config_bit)
    else $error("code changed without new clock tick");
  old_off_a: assert property (
    $past(presetn) && $changed(system_clock_select) |=>
    osc_enable[system_clock_select] &&
    (!osc_enable[$past(system_clock_select, 2)] ||
     ($past(system_clock_select, 2) == `SRC_LOW_POWER_INTERNAL_RC &&
      (watchdog_enable || fail_safe_active))))
    else $error("source enables wrong after switch");
  osc_read_a: assert property (
    rd_acc && paddr == `OFS_OSC_CTRL |->
    prdata[14:12] == system_clock_select && prdata[31:15] == 17'h0 &&
    prdata[11] == 1'b0 && prdata[4] == 1'b0 && prdata[2:1] == 2'h0)
    else $error("oscillator control read wrong");
  rand_top_a: assert property (
    rd_acc && paddr == `OFS_RAND_SHIFT |-> prdata[31:15] == 17'h0)
    else $error("random shift top bits set");
  hole_read_a: assert property (
    rd_acc && paddr > `OFS_UNLOCK |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule

bind clock_control clock_control_monitor clock_control_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .switch_permit_config_bit(switch_permit_config_bit),
  .initial_source_config(initial_source_config),
  .fail_safe_config_enable(fail_safe_config_enable),
  .watchdog_enable(watchdog_enable), .new_clock_tick(new_clock_tick),
  .osc_enable(osc_enable), .system_clock_select(system_clock_select),
  .fail_safe_active(fail_safe_active)
);
`default_nettype wire

// ### dv/clock_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defs.vh"
module clock_control_test;
  // ****************************************************************
  // stimulus and observed pins
  // ****************************************************************
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, w, x;
  logic        cfg_off = 1, fs_en = 1, wdt_en = 1, ost_ok = 0, pll_ok = 1;
  logic [2:0]  cfg_src = 3'h6;
  logic        ntick = 0, cfail = 0, alock = 1, xtick = 0, ptick = 0;
  logic        slp = 0, lp;
  wire [31:0]  prdata;
  wire         pready, pslverr, fs_act, a_en, a_src, ref_pin;
  wire [7:0]   osc_en;
  wire [2:0]   sys_sel;
  wire [8:0]   a_div;
  wire [1:0]   a_ref;
  logic [63:0] q[$], top;       // {mask, expected} per read
  int          n_fail = 0, n_tests = 0, k, e;

  always #25 pclk = ~pclk;
  // crystal pulses every other cycle
  always @(posedge pclk) xtick <= ~xtick;

  clock_control clock_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .switch_permit_config_bit(cfg_off),
    .initial_source_config(cfg_src), .fail_safe_config_enable(fs_en),
    .watchdog_enable(wdt_en), .osc_startup_done(ost_ok),
    .pll_locked(pll_ok), .new_clock_tick(ntick), .clock_fail_event(cfail),
    .aux_pll_lock_in(alock), .crystal_tick(xtick), .pwm_clock_tick(ptick),
    .sleep_mode(slp), .osc_enable(osc_en), .system_clock_select(sys_sel),
    .fail_safe_active(fs_act), .aux_pll_enable(a_en),
    .aux_divider_source_select(a_src), .aux_divide_ratio(a_div),
    .aux_reference_select(a_ref), .reference_clock_pin(ref_pin));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task cmp(input string s, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, ex, got);
    end
  endtask
  // one apb transfer; the idle edge first keeps drives one per step
  task apb(input logic wr_, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= wr_; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 0; penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
    q.push_back({m, ex & m});
    apb(0, a, 32'h0);
  endtask
  task unl;
    wr(`OFS_UNLOCK, `UNLOCK_KEY1);
    wr(`OFS_UNLOCK, `UNLOCK_KEY2);
  endtask
  task tick(input int n);
    repeat (n) begin
      @(posedge pclk) ntick <= 1;
      @(posedge pclk) ntick <= 0;
    end
  endtask
  // count reference pin rises over 64 cycles
  task refrun(input logic [31:0] c, input int ex);
    wr(`OFS_REF_CTRL, 32'h0);
    wr(`OFS_REF_CTRL, c);
    repeat (8) @(posedge pclk);
    e = 0;
    @(negedge pclk);
    lp = ref_pin;
    repeat (64) begin
      @(negedge pclk);
      if (ref_pin && !lp) e++;
      lp = ref_pin;
    end
    cmp("reference rises", ex, e);
  endtask

  // read results compared as they come back
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite) begin
      top = q.pop_front();
      cmp("prdata", top[31:0], prdata & top[63:32]);
    end

  // hang guard
  initial begin
    #2000000;
    n_fail++;
    end_of_test;
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    w = $urandom(11638);
    repeat (20) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    cmp("clock select", 32'h6, sys_sel);
    cmp("fail safe", 32'h0, fs_act);
    unl;
    wr(`OFS_OSC_CTRL, 32'h0201);
    rd(`OFS_OSC_CTRL, 32'h6020, 32'hfffff8ff);
    rd(`OFS_AUX_CTRL, `AUX_CTRL_RST, 32'hffffbfff);
    rd(`OFS_REF_CTRL, 32'h0, '1);
    rd(`OFS_RAND_SHIFT, 32'h0, '1);
    rd(8'h20, 32'h0, '1);
    cmp("aux ratio", 32'h1, a_div);
    // every divider code, last one 111 for pwm use
    for (k = 0; k < 8; k++) begin
      w = $urandom;
      w[15] = 1'b1;
      w[10:8] = k;
      wr(`OFS_AUX_CTRL, w);
      rd(`OFS_AUX_CTRL, (w & 32'ha7c0) | 32'h4000, '1);
      cmp("aux ratio", k ? 9'd1 << (7 - k) : 9'd256, a_div);
      cmp("aux ref", w[6] ? 2'b10 : {1'b0, w[7]}, a_ref);
      cmp("aux src", w[13], a_src);
      cmp("aux pll en", 1, a_en);
    end
    w = $urandom;
    wr(`OFS_REF_CTRL, w);
    rd(`OFS_REF_CTRL, w & 32'hbf00, '1);
    for (k = 0; k < 5; k++)
      refrun(32'h9000 | (k << 8), 32 >> k);
    refrun(32'h8100, 32);
    refrun(32'h8000, 0);
    refrun(32'h1100, 0);
    slp <= 1;
    refrun(32'h9100, 0);
    refrun(32'hb100, 16);
    slp <= 0;
    w = $urandom;
    wr(`OFS_RAND_SHIFT, w);
    x = w & 32'h7fff;
    rd(`OFS_RAND_SHIFT, x, '1);
    @(posedge pclk) ptick <= 1;
    @(posedge pclk) ptick <= 0;
    rd(`OFS_RAND_SHIFT, {x[13:0], ~(x[14] ^ x[13])}, 32'h7fff);
    // power-on again with switching permitted
    @(posedge pclk) presetn <= 0;
    cfg_off <= 0;
    cfg_src <= `SRC_FRC;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    cmp("fail safe", 32'h1, fs_act);
    @(posedge pclk) cfail <= 1;
    @(posedge pclk) cfail <= 0;
    rd(`OFS_OSC_CTRL, 32'h0028, '1);
    wr(`OFS_OSC_CTRL, 32'h0201);
    rd(`OFS_OSC_CTRL, 32'h0028, '1);
    unl;
    wr(`OFS_OSC_CTRL, 32'h0009);
    rd(`OFS_OSC_CTRL, 32'h0028, '1);
    unl;
    wr(`OFS_OSC_CTRL, 32'h0209);
    rd(`OFS_OSC_CTRL, 32'h0201, '1);
    tick(12);
    cmp("clock select", 32'h0, sys_sel);
    @(posedge pclk) ost_ok <= 1;
    repeat (3) @(posedge pclk);
    tick(9);
    cmp("clock select", 32'h0, sys_sel);
    tick(1);
    @(posedge pclk);
    cmp("clock select", `SRC_PRI, sys_sel);
    repeat (2) @(posedge pclk);
    cmp("osc enable", 32'h24, osc_en & 8'h25);
    rd(`OFS_OSC_CTRL, 32'h2220, '1);
    end_of_test;
  end
endmodule
`default_nettype wire

// ### rtl/clk_ctrl_defs.vh
`ifndef CLK_CTRL_DEFS_VH
`define CLK_CTRL_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_OSC_CTRL   8'h00
`define OFS_AUX_CTRL   8'h04
`define OFS_REF_CTRL   8'h08
`define OFS_RAND_SHIFT 8'h0c
`define OFS_UNLOCK     8'h10

// ****************************************************************
// reset values
// ****************************************************************
`define AUX_CTRL_RST   16'h2700
`define REF_CTRL_RST   16'h0000
`define RAND_RST       15'h0000

// ****************************************************************
// unlock keys, written in order to the unlock register
// ****************************************************************
`define UNLOCK_KEY1    8'h46
`define UNLOCK_KEY2    8'h57

// ****************************************************************
// source codes and hand-over count
// ****************************************************************
`define SRC_FRC        3'h0
`define SRC_FRC_PLL    3'h1
`define SRC_PRI        3'h2
`define SRC_PRI_PLL    3'h3
`define SRC_LOW_POWER_INTERNAL_RC       3'h5
`define HANDOVER_CYC   4'ha

`endif

// ### rtl/clock_control.v
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defs.vh"

module clock_control (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // configuration word straps
  input  wire        switch_permit_config_bit,
  input  wire [2:0]  initial_source_config,
  input  wire        fail_safe_config_enable,
  input  wire        watchdog_enable,
  // oscillator and pll status
  input  wire        osc_startup_done,
  input  wire        pll_locked,
  input  wire        new_clock_tick,
  input  wire        clock_fail_event,
  input  wire        aux_pll_lock_in,
  // tick sources and power state
  input  wire        crystal_tick,
  input  wire        pwm_clock_tick,
  input  wire        sleep_mode,
  // clock tree controls
  output reg  [7:0]  osc_enable,
  output wire [2:0]  system_clock_select,
  output wire        fail_safe_active,
  output wire        aux_pll_enable,
  output wire        aux_divider_source_select,
  output wire [8:0]  aux_divide_ratio,
  output wire [1:0]  aux_reference_select,
  // reference clock pin
  output reg         reference_clock_pin
);

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_WAIT  = 2'd1;
  localparam [1:0] ST_COUNT = 2'd2;

  // ****************************************************************
  // functions
  // ****************************************************************
  // one-hot oscillator enable for a source code
  function [7:0] src_onehot;
    input [2:0] code;
    begin
      src_onehot = 8'h01 << code;
    end
  endfunction

  // aux divider code to divide ratio
  function [8:0] aux_ratio;
    input [2:0] code;
    begin
      if (code == 3'h0) begin
        aux_ratio = 9'h100;
      end else begin
        aux_ratio = 9'h001 << (3'h7 - code);
      end
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  reg [2:0]  cur_src_reg;    // current source code
  reg [2:0]  new_src_reg;    // requested source code
  reg        req_reg;        // switch request
  reg        lock_reg;       // pll lock status
  reg        fail_reg;       // clock fail flag
  reg [1:0]  state_reg;      // switch sequencer
  reg [3:0]  hand_cnt_reg;   // new-clock cycle count
  reg        boot_done_reg;  // straps captured
  reg [1:0]  unlock_reg;     // unlock key progress
  reg [15:0] aux_reg;        // aux clock control
  reg [15:0] ref_reg;        // reference output control
  reg [14:0] rand_reg;       // random shift value
  reg [14:0] ref_cnt_reg;    // reference divider counter

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire wr      = access & pwrite;
  wire mapped  = (paddr == `OFS_OSC_CTRL) | (paddr == `OFS_AUX_CTRL) |
                 (paddr == `OFS_REF_CTRL) | (paddr == `OFS_RAND_SHIFT) |
                 (paddr == `OFS_UNLOCK);
  // zero-wait slave, unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  wire wr_osc    = wr & (paddr == `OFS_OSC_CTRL) & unlock_reg[1];
  wire wr_aux    = wr & (paddr == `OFS_AUX_CTRL);
  wire wr_ref    = wr & (paddr == `OFS_REF_CTRL);
  wire wr_rand   = wr & (paddr == `OFS_RAND_SHIFT);
  wire wr_unlock = wr & (paddr == `OFS_UNLOCK);

  // ****************************************************************
  // switch permission
  // ****************************************************************
  // programmed to zero means switching and monitor allowed
  wire permit = ~switch_permit_config_bit;
  assign fail_safe_active = permit & fail_safe_config_enable;

  // readiness of the requested source
  wire need_xtal = (new_src_reg == `SRC_PRI) |
                   (new_src_reg == `SRC_PRI_PLL);
  wire need_pll  = (new_src_reg == `SRC_FRC_PLL) |
                   (new_src_reg == `SRC_PRI_PLL);
  wire src_ready = (~need_xtal | osc_startup_done) &
                   (~need_pll | lock_reg);

  wire start_sw  = (state_reg == ST_IDLE) & req_reg &
                   (new_src_reg != cur_src_reg);
  wire done_sw   = (state_reg == ST_COUNT) & new_clock_tick &
                   (hand_cnt_reg == `HANDOVER_CYC - 4'h1);

  assign system_clock_select = cur_src_reg;

  // ****************************************************************
  // unlock sequence
  // ****************************************************************
  // two keys in order arm exactly one oscillator control write;
  // any other write breaks the sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_reg <= 2'd0;
    end else if (wr_unlock && pwdata[7:0] == `UNLOCK_KEY1) begin
      unlock_reg <= 2'd1;
    end else if (wr_unlock && pwdata[7:0] == `UNLOCK_KEY2 &&
                 unlock_reg == 2'd1) begin
      unlock_reg <= 2'd2;
    end else if (wr) begin
      unlock_reg <= 2'd0;
    end
  end

  // ****************************************************************
  // clock switch sequencer
  // ****************************************************************
  // presetn is the power-on reset; no other reset reaches here
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_src_reg   <= 3'h0;
      new_src_reg   <= 3'h0;
      req_reg       <= 1'b0;
      state_reg     <= ST_IDLE;
      hand_cnt_reg  <= 4'h0;
      boot_done_reg <= 1'b0;
    end else if (!boot_done_reg || !permit) begin
      // straps captured after release, followed while switching off
      cur_src_reg   <= initial_source_config;
      new_src_reg   <= initial_source_config;
      req_reg       <= 1'b0;
      state_reg     <= ST_IDLE;
      hand_cnt_reg  <= 4'h0;
      boot_done_reg <= 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (req_reg && new_src_reg == cur_src_reg) begin
            req_reg <= 1'b0;
          end else if (req_reg) begin
            state_reg <= ST_WAIT;
          end else if (wr_osc) begin
            // new code accepted only between switches
            new_src_reg <= pwdata[10:8];
            req_reg     <= pwdata[0];
          end
        end
        ST_WAIT: begin
          if (src_ready) begin
            state_reg    <= ST_COUNT;
            hand_cnt_reg <= 4'h0;
          end
        end
        ST_COUNT: begin
          if (done_sw) begin
            cur_src_reg <= new_src_reg;
            req_reg     <= 1'b0;
            state_reg   <= ST_IDLE;
          end else if (new_clock_tick) begin
            hand_cnt_reg <= hand_cnt_reg + 4'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // lock and fail status
  // ****************************************************************
  // a fail event in the clearing cycle still sets the flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      if (start_sw) begin
        lock_reg <= 1'b0;
      end else begin
        lock_reg <= pll_locked;
      end
      if (clock_fail_event && fail_safe_active) begin
        fail_reg <= 1'b1;
      end else if (start_sw || (wr_osc && !pwdata[3])) begin
        fail_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // oscillator enables
  // ****************************************************************
  // the running source, the one being started and, with watchdog or fail safe on,
  // the low-power rc stay on, so any other old source drops at the hand-over
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_enable <= 8'h00;
    end else begin
      osc_enable <= src_onehot(cur_src_reg) |
                    ((state_reg != ST_IDLE) ?
                     src_onehot(new_src_reg) : 8'h00) |
                    ((watchdog_enable | fail_safe_active) ?
                     src_onehot(`SRC_LOW_POWER_INTERNAL_RC) : 8'h00);
    end
  end

  // ****************************************************************
  // aux and reference control registers
  // ****************************************************************
  // unimplemented bits never store; lock bit is live status
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_reg <= `AUX_CTRL_RST;
      ref_reg <= `REF_CTRL_RST;
    end else begin
      if (wr_aux) begin
        aux_reg <= {pwdata[15], 1'b0, pwdata[13], 2'b00,
                    pwdata[10:6], 6'h00};
      end
      if (wr_ref) begin
        // divider field written regardless; software disables first
        ref_reg <= {pwdata[15], 1'b0, pwdata[13:8], 8'h00};
      end
    end
  end

  assign aux_pll_enable            = aux_reg[15];
  wire   aux_locked                = aux_reg[15] & aux_pll_lock_in;
  assign aux_divider_source_select = aux_reg[13];
  assign aux_divide_ratio          = aux_ratio(aux_reg[10:8]);
  // 2'b10 fast rc, 2'b01 primary, 2'b00 no clock
  assign aux_reference_select = aux_reg[6] ? 2'b10 :
                                (aux_reg[7] ? 2'b01 : 2'b00);

  // ****************************************************************
  // reference clock divider
  // ****************************************************************
  wire ref_tick = ref_reg[12] ? crystal_tick : 1'b1;
  wire ref_run  = ref_reg[15] &
                  (~sleep_mode | ref_reg[13]);

  // counter bit k toggles every 2^k ticks, giving divide by 2^(k+1);
  // code 0 passes ticks, so system clock at code 0 shows a high level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_reg         <= 15'h0000;
      reference_clock_pin <= 1'b0;
    end else if (!ref_run) begin
      ref_cnt_reg         <= 15'h0000;
      reference_clock_pin <= 1'b0;
    end else begin
      if (ref_tick) begin
        ref_cnt_reg <= ref_cnt_reg + 15'h0001;
      end
      if (ref_reg[11:8] == 4'h0) begin
        reference_clock_pin <= ref_tick;
      end else begin
        reference_clock_pin <= ref_cnt_reg[ref_reg[11:8] - 4'h1];
      end
    end
  end

  // ****************************************************************
  // random shift value
  // ****************************************************************
  // xnor feedback keeps all-zeros a legal seed after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rand_reg <= `RAND_RST;
    end else if (wr_rand) begin
      rand_reg <= pwdata[14:0];
    end else if (pwm_clock_tick) begin
      rand_reg <= {rand_reg[13:0],
                   ~(rand_reg[14] ^ rand_reg[13])};
    end
  end

  // ****************************************************************
  // read data, captured in the setup cycle
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `OFS_OSC_CTRL: begin
          prdata <= {17'h00000, cur_src_reg, 1'b0, new_src_reg,
                     2'b00, lock_reg, 1'b0, fail_reg, 2'b00,
                     req_reg};
        end
        `OFS_AUX_CTRL: begin
          prdata <= {16'h0000, aux_reg[15], aux_locked,
                     aux_reg[13:0]};
        end
        `OFS_REF_CTRL: begin
          prdata <= {16'h0000, ref_reg};
        end
        `OFS_RAND_SHIFT: begin
          prdata <= {17'h00000, rand_reg};
        end
        `OFS_UNLOCK: begin
          prdata <= {30'h00000000, unlock_reg};
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

`default_nettype wire
